// ### hw/pmmb_consts.svh
// Register offsets, field positions, reset values and timing counts of the MAC-side block
`ifndef PMMB_CONSTS_SVH
`define PMMB_CONSTS_SVH
`define PMMB_ADDR_BASIC    5'h00
`define PMMB_ADDR_STATUS   5'h10
`define PMMB_ADDR_MAPBYP   5'h17
`define PMMB_ADDR_PHYCTRL  5'h19
`define PMMB_ADDR_CDBIST   5'h1b
`define PMMB_BC_LOOP       14
`define PMMB_BC_SPEED      13
`define PMMB_BC_DUPLEX     8
`define PMMB_PS_LOOP       3
`define PMMB_PS_DUPLEX     2
`define PMMB_PS_SPEED      1
`define PMMB_PC_HBEAT      11
`define PMMB_PC_PRBS15     10
`define PMMB_PC_STATUS     9
`define PMMB_PC_START      8
`define PMMB_MB_RMII       5
`define PMMB_MB_UNDER      3
`define PMMB_MB_OVER       2
`define PMMB_CD_CONT       5
`define PMMB_BC_RESET      16'h2000
`define PMMB_MB_RESET      16'h0001
`define PMMB_PRBS_SEED     15'h7fff
`define PMMB_RMII_DIV      4'ha
`define PMMB_COL_BITS      4'h7
`define PMMB_SQE_DLY_NS    1000
`define PMMB_SQE_WID_NS    1000
`define PMMB_BIST_WARM     3'h4
`define PMMB_BIST_PKT      8'h40
`define PMMB_BIST_GAP      8'h18
`define PMMB_EB_HIGH       6'h1c
`endif

// ### hw/pmmb_pkg.sv
// Types shared by the MAC-side block
package pmmb_pkg;
  typedef struct packed {
    logic       loop;
    logic       spd100;
    logic       fdx;
    logic       rmii;
    logic       hbeat;
    logic       prbs15;
    logic       cont;
    logic       bist;
    logic [1:0] thr;
  } pmmb_cfg_s;
  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } pmmb_tx_s;
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } pmmb_rx_s;
  typedef struct packed {
    logic sd;
    logic twoZeros;
    logic squelch;
    logic stb;
  } pmmb_line_s;
endpackage : pmmb_pkg

// ### hw/pmmb_mac_side.sv
// MAC-facing MII/RMII data paths with loopback, collision, carrier and PRBS self-test
`timescale 1ns/10ps
`include "pmmb_consts.svh"

module pmmb_mac_side
  import pmmb_pkg::*;
#(
  parameter int LINK_NS = 400
)(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Management register port
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] regRdData,
  // Link clock (MII clock or RMII reference)
  input  wire logic        linkClk,
  // MAC transmit and receive
  input  wire pmmb_tx_s    macTx,
  input  wire logic        rmiiTxEn,
  input  wire logic [1:0]  rmiiTxD,
  output pmmb_rx_s         macRx,
  output logic      [1:0]  rmiiRxD,
  output logic             rmiiRxDv,
  output logic             rmiiRxEr,
  output logic             col,
  output logic             crs,
  // Line side, already in the link domain
  input  wire pmmb_rx_s    lineRx,
  input  wire pmmb_line_s  lineStat,
  output pmmb_tx_s         lineTx
);

  localparam int SQE_DLY = (`PMMB_SQE_DLY_NS / LINK_NS) < 1 ? 1 : `PMMB_SQE_DLY_NS / LINK_NS;
  localparam int SQE_WID = (`PMMB_SQE_WID_NS / LINK_NS) < 1 ? 1 : `PMMB_SQE_WID_NS / LINK_NS;
  // Latency in bits indexed by {threshold, not 100M}
  localparam logic [5:0] THR_TBL [0:7] = '{6'h0e, 6'h0c, 6'h02, 6'h08,
                                          6'h06, 6'h04, 6'h0a, 6'h08};

  // One PRBS step of four bits; upper bits of the register are unused for 9-bit mode
  function automatic logic [18:0] prbsGen(logic [14:0] s, logic l15);
    logic [14:0] st;
    logic [3:0]  n;
    logic        b;
    st = s;
    n  = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      b    = l15 ? (st[14] ^ st[13]) : (st[8] ^ st[4]);
      n[i] = b;
      st   = {st[13:0], b};
    end
    return {n, st};
  endfunction : prbsGen

  // Self-synchronising check: predict each bit, then shift the received bit in
  function automatic logic [15:0] prbsChk(logic [14:0] s, logic [3:0] rx, logic l15);
    logic [14:0] st;
    logic        miss;
    miss = 1'b0;
    st   = s;
    for (int i = 0; i < 4; i++)
    begin
      miss = miss | ((l15 ? (st[14] ^ st[13]) : (st[8] ^ st[4])) != rx[i]);
      st   = {st[13:0], rx[i]};
    end
    return {miss, st};
  endfunction : prbsChk

  // ---------------- Core domain ----------------
  logic [15:0] bc_q, pc_q, mb_q, cd_q;
  logic        startTog_q;
  logic [3:0]  stMeta_q, st_q, stLink;
  logic [7:0]  grayMeta_q, gray_q, errCnt, errGray_q;
  pmmb_cfg_s   cfgCore;

  // Register writes; read-only fields are never stored
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bc_q       <= `PMMB_BC_RESET;
      pc_q       <= 16'h0000;
      mb_q       <= `PMMB_MB_RESET;
      cd_q       <= 16'h0000;
      startTog_q <= 1'b0;
    end
    else if (regWrEn)
    begin
      unique case (regAddr)
        `PMMB_ADDR_BASIC:   bc_q <= regWrData;
        `PMMB_ADDR_MAPBYP:  mb_q <= regWrData & ~16'h000c;
        `PMMB_ADDR_CDBIST:  cd_q <= {8'h00, regWrData[7:0]};
        `PMMB_ADDR_PHYCTRL:
        begin
          pc_q       <= regWrData & ~16'h0200;
          startTog_q <= ~startTog_q;
        end
        default: ;
      endcase
    end
  end

  // Status back from the link domain; levels through two flops, count as gray code
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stMeta_q   <= 4'h0;
      st_q       <= 4'h0;
      grayMeta_q <= 8'h00;
      gray_q     <= 8'h00;
    end
    else
    begin
      stMeta_q   <= stLink;
      st_q       <= stMeta_q;
      grayMeta_q <= errGray_q;
      gray_q     <= grayMeta_q;
    end
  end

  // Gray to binary
  always_comb
  begin
    errCnt[7] = gray_q[7];
    for (int i = 6; i >= 0; i--)
      errCnt[i] = errCnt[i+1] ^ gray_q[i];
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
      regRdData <= 16'h0000;
    else
    begin
      unique case (regAddr)
        `PMMB_ADDR_BASIC:   regRdData <= bc_q;
        `PMMB_ADDR_STATUS:  regRdData <= {12'h000, st_q[0], bc_q[`PMMB_BC_DUPLEX],
                                          ~bc_q[`PMMB_BC_SPEED], 1'b0};
        `PMMB_ADDR_MAPBYP:  regRdData <= mb_q | {12'h000, st_q[2], st_q[1], 2'b00};
        `PMMB_ADDR_PHYCTRL: regRdData <= pc_q | {6'h00, st_q[3], 9'h000};
        `PMMB_ADDR_CDBIST:  regRdData <= {errCnt, cd_q[7:0]};
        default:            regRdData <= 16'h0000;
      endcase
    end
  end

  assign cfgCore = '{loop:   bc_q[`PMMB_BC_LOOP],
                     spd100: bc_q[`PMMB_BC_SPEED],
                     fdx:    bc_q[`PMMB_BC_DUPLEX],
                     rmii:   mb_q[`PMMB_MB_RMII],
                     hbeat:  pc_q[`PMMB_PC_HBEAT],
                     prbs15: pc_q[`PMMB_PC_PRBS15],
                     cont:   cd_q[`PMMB_CD_CONT],
                     bist:   pc_q[`PMMB_PC_START],
                     thr:    mb_q[1:0]};

  // ---------------- Link domain ----------------
  logic        rstMeta_q, linkRst_q;
  pmmb_cfg_s   cfgMeta_q, cfg;
  logic [2:0]  tog_q;
  logic        clr, take, nibSlot, txAct, srcEn, rxV, rxStb, rxEr;
  logic [3:0]  div_q, txNib, srcNib, rxD;
  logic        slot_q, txEnPrev_q, txStart;
  logic [1:0]  txLow_q;
  logic [14:0] prbs_q, chk_q;
  logic [3:0]  genNib_q;
  logic [7:0]  pkt_q;
  logic        bistOn_q;
  logic [18:0] genNext;
  logic [15:0] chkRes;

  // Reset, configuration and start event into the link domain
  always_ff @(posedge linkClk)
  begin
    rstMeta_q <= srst;
    linkRst_q <= rstMeta_q;
    cfgMeta_q <= cfgCore;
    cfg       <= cfgMeta_q;
    tog_q     <= {tog_q[1:0], startTog_q};
  end
  assign clr = tog_q[2] ^ tog_q[1];

  // Tenth-clock strobe for RMII at 10M, and dibit pairing into nibbles
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
    begin
      div_q      <= 4'h0;
      slot_q     <= 1'b0;
      txLow_q    <= 2'b00;
      txEnPrev_q <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == `PMMB_RMII_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
      if (take)
      begin
        // A frame always opens on a low dibit, whatever phase the free-running slot had
        txEnPrev_q <= rmiiTxEn;
        slot_q     <= txStart | ~slot_q;
        if (!slot_q || txStart)
          txLow_q <= rmiiTxD;
      end
    end
  end
  assign take    = cfg.spd100 | (div_q == 4'h0);
  assign txStart = rmiiTxEn & ~txEnPrev_q;
  assign nibSlot = cfg.rmii ? (take & slot_q & ~txStart) : 1'b1;
  assign txAct   = cfg.rmii ? rmiiTxEn : macTx.en;
  assign txNib   = cfg.rmii ? {rmiiTxD, txLow_q} : macTx.d;

  // PRBS generator; packet mode leaves a gap, continuous mode never does
  assign genNext = prbsGen(prbs_q, cfg.prbs15);
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || !cfg.bist)
    begin
      prbs_q   <= `PMMB_PRBS_SEED;
      genNib_q <= 4'h0;
      pkt_q    <= 8'h00;
      bistOn_q <= 1'b0;
    end
    else if (nibSlot)
    begin
      prbs_q   <= genNext[14:0];
      genNib_q <= genNext[18:15];
      pkt_q    <= (pkt_q == `PMMB_BIST_PKT + `PMMB_BIST_GAP - 8'h01) ? 8'h00 : pkt_q + 8'h01;
      bistOn_q <= cfg.cont | (pkt_q < `PMMB_BIST_PKT);
    end
  end
  assign srcEn  = cfg.bist ? bistOn_q : txAct;
  assign srcNib = cfg.bist ? genNib_q : txNib;

  // Medium transmit, silenced while looped back
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
      lineTx <= '0;
    else if (nibSlot)
    begin
      lineTx.en <= srcEn & ~cfg.loop;
      lineTx.d  <= (srcEn & ~cfg.loop) ? srcNib : 4'h0;
    end
  end

  // Receive source: looped transmit data or the line
  assign rxV   = cfg.loop ? srcEn : lineRx.dv;
  assign rxD   = cfg.loop ? srcNib : lineRx.d;
  assign rxStb = cfg.loop ? nibSlot : (cfg.rmii ? lineStat.stb : 1'b1);
  assign rxEr  = ~cfg.loop & lineRx.er & lineRx.dv;

  // MII receive outputs
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || cfg.rmii)
      macRx <= '0;
    else
      macRx <= '{dv: rxV, er: rxEr, d: rxV ? rxD : 4'h0};
  end

  // Carrier and collision state
  logic       carrier_q, rxFirst_q, txPrev_q, colAct, colRep, sqeOn;
  logic [3:0] colBits_q;
  logic [7:0] sqeCnt_q;
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || !rxV)
      carrier_q <= 1'b0;
    else if (cfg.loop || (cfg.spd100 ? (lineStat.sd & lineStat.twoZeros) : lineStat.squelch))
      carrier_q <= 1'b1;
  end
  assign crs    = carrier_q | (~cfg.fdx & txAct);
  assign colAct = ~cfg.fdx & ~cfg.loop & txAct & carrier_q;

  // Who started first decides delayed or immediate reporting
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
    begin
      rxFirst_q <= 1'b0;
      colBits_q <= 4'h0;
    end
    else
    begin
      if (!colAct)
        rxFirst_q <= carrier_q & ~txAct;
      if (!colAct)
        colBits_q <= 4'h0;
      else if (rxStb && colBits_q < `PMMB_COL_BITS)
        colBits_q <= colBits_q + 4'h4;
    end
  end
  // Noise on the wire must persist seven bits before a 10M transmit collision shows
  assign colRep = colAct & (cfg.spd100 | rxFirst_q | (colBits_q >= `PMMB_COL_BITS));

  // Heartbeat pulse after each 10M half-duplex transmission
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
    begin
      txPrev_q <= 1'b0;
      sqeCnt_q <= 8'h00;
    end
    else
    begin
      txPrev_q <= txAct;
      if (txPrev_q && !txAct && cfg.hbeat && !cfg.spd100 && !cfg.fdx)
        sqeCnt_q <= 8'h01;
      else if (sqeCnt_q != 8'h00)
        sqeCnt_q <= (sqeCnt_q == 8'(SQE_DLY + SQE_WID)) ? 8'h00 : sqeCnt_q + 8'h01;
    end
  end
  assign sqeOn = ~cfg.fdx & (sqeCnt_q > 8'(SQE_DLY));
  assign col   = colRep | sqeOn;

  // RMII receive elasticity buffer, bit wide
  logic        ebuf_q [0:31];
  logic [5:0]  wr_q, rd_q, fill, thrBits;
  logic        ebRun_q, ebErr_q, frmErr_q, under_q, over_q, rxPrev_q;
  logic [1:0]  rdBits;
  assign fill    = wr_q - rd_q;
  assign thrBits = THR_TBL[{cfg.thr, ~cfg.spd100}];
  assign rdBits  = {ebuf_q[5'(rd_q[4:0] + 5'h01)], ebuf_q[rd_q[4:0]]};

  // Overrun drops the nibble; underrun repeats nothing and reads as an error
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || !cfg.rmii || (!ebRun_q && !rxV))
    begin
      wr_q    <= 6'h00;
      rd_q    <= 6'h00;
      ebRun_q <= 1'b0;
    end
    else
    begin
      if (rxV && rxStb && fill <= `PMMB_EB_HIGH)
      begin
        for (int i = 0; i < 4; i++)
          ebuf_q[5'(wr_q[4:0] + 5'(i))] <= rxD[i];
        wr_q <= wr_q + 6'h04;
      end
      if (!ebRun_q && fill >= thrBits)
        ebRun_q <= 1'b1;
      else if (ebRun_q && take && fill >= 6'h02)
        rd_q <= rd_q + 6'h02;
      else if (ebRun_q && take && !rxV)
        ebRun_q <= 1'b0;
    end
  end

  // Per-frame error and sticky under/overrun flags; a new event beats the frame-start clear
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
    begin
      ebErr_q  <= 1'b0;
      frmErr_q <= 1'b0;
      under_q  <= 1'b0;
      over_q   <= 1'b0;
      rxPrev_q <= 1'b0;
    end
    else
    begin
      rxPrev_q <= rxV;
      if (cfg.rmii && ebRun_q && take && fill < 6'h02 && rxV)
      begin
        ebErr_q <= 1'b1;
        under_q <= 1'b1;
      end
      else if (cfg.rmii && rxV && rxStb && fill > `PMMB_EB_HIGH)
      begin
        ebErr_q <= 1'b1;
        over_q  <= 1'b1;
      end
      else if (rxV && !rxPrev_q)
      begin
        ebErr_q <= 1'b0;
        under_q <= 1'b0;
        over_q  <= 1'b0;
      end
      if (rxEr)
        frmErr_q <= 1'b1;
      else if (rxV && !rxPrev_q)
        frmErr_q <= 1'b0;
    end
  end

  // RMII receive outputs, updated only on the data strobe
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || !cfg.rmii)
    begin
      rmiiRxD  <= 2'b00;
      rmiiRxDv <= 1'b0;
      rmiiRxEr <= 1'b0;
    end
    else if (take)
    begin
      rmiiRxDv <= ebRun_q & ((fill >= 6'h02) | rxV); // No empty dibit after the frame drains
      rmiiRxD  <= (ebRun_q && fill >= 6'h02) ? (rdBits ^ {2{ebErr_q}}) : 2'b00;
      rmiiRxEr <= ebRun_q & (ebErr_q | frmErr_q);
    end
  end

  // Self-test checker and miscompare counter
  logic [2:0] warm_q;
  logic       pass_q, fail_q;
  logic [7:0] errCnt_q;
  assign chkRes = prbsChk(chk_q, rxD, cfg.prbs15);
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q || clr)
    begin
      chk_q    <= 15'h0000;
      warm_q   <= 3'h0;
      pass_q   <= 1'b0;
      fail_q   <= 1'b0;
      errCnt_q <= 8'h00;
    end
    else if (cfg.bist && rxV && rxStb)
    begin
      chk_q <= chkRes[14:0];
      if (warm_q < `PMMB_BIST_WARM)
        warm_q <= warm_q + 3'h1;
      else if (chkRes[15])
      begin
        fail_q   <= 1'b1;
        pass_q   <= 1'b0;
        errCnt_q <= (errCnt_q == 8'hff) ? 8'hff : errCnt_q + 8'h01;
      end
      else if (!fail_q)
        pass_q <= 1'b1;
    end
    else if (!rxV)
      warm_q <= 3'h0; // A packet gap breaks the bit history, so resynchronise
  end

  // Status words leaving the link domain
  always_ff @(posedge linkClk)
  begin
    if (linkRst_q)
      errGray_q <= 8'h00;
    else
      errGray_q <= errCnt_q ^ (errCnt_q >> 1);
  end
  assign stLink = {pass_q, under_q, over_q, cfg.loop};

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (linkRst_q);

  a_loop_silent: assert property (cfg.loop && nibSlot |=> !lineTx.en)
    else $error("medium driven during loopback");
  a_loop_echo: assert property (cfg.loop && !cfg.rmii && !cfg.bist && macTx.en |=> macRx.dv)
    else $error("looped transmit missing on receive");
  a_fdx_nocol: assert property (cfg.fdx |-> !col)
    else $error("collision in full duplex");
  a_col_delay: assert property ($rose(colAct) && !cfg.spd100 && !rxFirst_q |-> !colRep)
    else $error("10M transmit collision not delayed");
  a_col_rxfirst: assert property (colAct && rxFirst_q |-> col)
    else $error("receive collision not immediate");
  a_crs_fdx: assert property (cfg.fdx && !carrier_q |-> !crs)
    else $error("carrier for transmit in full duplex");
  a_bist_latch: assert property (fail_q && !clr |=> !pass_q)
    else $error("self-test pass after miscompare");
  a_cnt_sat: assert property (errCnt_q == 8'hff && !clr |=> errCnt_q == 8'hff)
    else $error("error count wrapped");
  a_eb_flag: assert property (take && ebRun_q && ebErr_q && cfg.rmii |=> rmiiRxEr)
    else $error("buffer error not on receive error");

endmodule : pmmb_mac_side

// ### bench/pmmb_mac_model.sv
// MAC partner model: drives MII or RMII transmit and gathers MII receive nibbles
`timescale 1ns/10ps

module pmmb_mac_model
  import pmmb_pkg::*;
(
  // Link clock from the block side
  input  wire logic      linkClk,
  // MAC transmit toward the block
  output pmmb_tx_s       macTx,
  output logic           rmiiTxEn,
  output logic [1:0]     rmiiTxD,
  // MAC receive from the block
  input  wire pmmb_rx_s  macRx
);
  logic [3:0] rxSeen [$];

  // Quiet start
  initial
  begin
    macTx    = '0;
    rmiiTxEn = 1'b0;
    rmiiTxD  = 2'h0;
  end

  // The MAC samples receive on the rising edge
  always @(posedge linkClk)
  begin
    if (macRx.dv === 1'b1)
      rxSeen.push_back(macRx.d);
  end

  // Back-to-back nibbles, low nibble first; idle data inverted so stale data never matches
  task automatic send_mii(input logic [31:0] word, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge linkClk);
      macTx.en <= 1'b1;
      macTx.d  <= word[4*i +: 4];
    end
    @(negedge linkClk);
    macTx.en <= 1'b0;
    macTx.d  <= ~macTx.d;
  endtask : send_mii

  // One nibble as two dibits, low first, each held for div reference clocks
  task automatic send_rmii(input logic [3:0] nib, input int div);
    for (int i = 0; i < 2; i++)
    begin
      @(negedge linkClk);
      rmiiTxEn <= 1'b1;
      rmiiTxD  <= nib[2*i +: 2];
      repeat (div - 1) @(negedge linkClk);
    end
    @(negedge linkClk);
    rmiiTxEn <= 1'b0;
    rmiiTxD  <= ~rmiiTxD;
  endtask : send_rmii
endmodule : pmmb_mac_model

// ### bench/tb_top.sv
// Self-checking bench for the MAC-side block
`timescale 1ns/10ps
`include "pmmb_consts.svh"

module tb_top
  import pmmb_pkg::*;
;
  logic        core_clk, srst, linkClk, regWrEn;
  logic [4:0]  regAddr;
  logic [15:0] regWrData, regRdData, rv;
  pmmb_tx_s    macTx, lineTx;
  pmmb_rx_s    macRx, lineRx;
  pmmb_line_s  lineStat;
  logic        rmiiTxEn, rmiiRxDv, rmiiRxEr, col, crs;
  logic [1:0]  rmiiTxD, rmiiRxD;
  logic [3:0]  lineSeen [$];
  int          failCount, cmpCount;

  // Core clock, 10 ns
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Link clock, 125 ns, offset from the core clock
  initial
  begin
    linkClk = 1'b0;
    #3.1;
    forever #62.5 linkClk = ~linkClk;
  end

  // Short heartbeat timing so delay and width are 8 link cycles
  pmmb_mac_side #(.LINK_NS(125)) DUT (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(regRdData), .linkClk(linkClk), .macTx(macTx),
    .rmiiTxEn(rmiiTxEn), .rmiiTxD(rmiiTxD), .macRx(macRx), .rmiiRxD(rmiiRxD),
    .rmiiRxDv(rmiiRxDv), .rmiiRxEr(rmiiRxEr), .col(col), .crs(crs), .lineRx(lineRx),
    .lineStat(lineStat), .lineTx(lineTx));

  pmmb_mac_model macModel (
    .linkClk(linkClk), .macTx(macTx), .rmiiTxEn(rmiiTxEn), .rmiiTxD(rmiiTxD), .macRx(macRx));

  // What reaches the medium
  always @(posedge linkClk)
  begin
    if (lineTx.en === 1'b1)
      lineSeen.push_back(lineTx.d);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic lcyc(input int n);
    repeat (n) @(negedge linkClk);
  endtask : lcyc

  // Write pulse, then time for the link domain to follow
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
    lcyc(6);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    repeat (2) @(negedge core_clk);
    d = regRdData;
  endtask : rd

  // Line receive with all carrier qualifiers following valid
  task automatic line(input logic dv, input logic [3:0] d);
    @(negedge linkClk);
    lineRx   <= {dv, 1'b0, d};
    lineStat <= {dv, dv, dv, 1'b0};
  endtask : line

  task automatic t_regs();
    rd(`PMMB_ADDR_BASIC, rv);
    chk(rv, `PMMB_BC_RESET);
    rd(`PMMB_ADDR_MAPBYP, rv);
    chk(rv & 16'h0023, `PMMB_MB_RESET);
    wr(5'h1e, 16'hffff);
    rd(5'h1e, rv);
    chk(rv, 16'h0000);
    rd(`PMMB_ADDR_PHYCTRL, rv);
    chk(rv[`PMMB_PC_STATUS], 1'b0);
  endtask : t_regs

  task automatic t_loop();
    int n0;
    wr(`PMMB_ADDR_BASIC, 16'h6000);
    rd(`PMMB_ADDR_STATUS, rv);
    chk(rv[3:1], 3'h4);
    macModel.rxSeen.delete();
    n0 = lineSeen.size();
    macModel.send_mii(32'h9c35, 4);
    lcyc(6);
    chk(16'(macModel.rxSeen.size()), 16'h4);
    for (int i = 0; i < 4; i++)
      chk(macModel.rxSeen[i], 4'(16'h9c35 >> 4*i));
    chk(16'(lineSeen.size() - n0), 16'h0);
    wr(`PMMB_ADDR_BASIC, 16'h2000);
    rd(`PMMB_ADDR_STATUS, rv);
    chk(rv[3], 1'b0);
  endtask : t_loop

  task automatic t_tx();
    lineSeen.delete();
    fork
      macModel.send_mii(32'h3e71, 4);
      begin
        lcyc(2);
        chk(crs, 1'b1);
      end
    join
    lcyc(4);
    chk(16'(lineSeen.size()), 16'h4);
    for (int i = 0; i < 4; i++)
      chk(lineSeen[i], 4'(16'h3e71 >> 4*i));
  endtask : t_tx

  // Receive first, then transmit, at 100M in either duplex
  task automatic t_col100(input logic fdx);
    wr(`PMMB_ADDR_BASIC, 16'h2000 | {7'h0, fdx, 8'h00});
    line(1'b1, 4'h5);
    lcyc(2);
    chk(crs, 1'b1);
    fork
      macModel.send_mii(32'h1111, 4);
      begin
        lcyc(2);
        chk(col, !fdx);
      end
    join
    line(1'b0, 4'h0);
    lcyc(3);
    chk(crs, 1'b0);
    fork
      macModel.send_mii(32'h1111, 4);
      begin
        lcyc(2);
        chk(crs, !fdx);
      end
    join
  endtask : t_col100

  // Transmit first at 10M: collision waits for seven received bits
  task automatic t_col10();
    wr(`PMMB_ADDR_BASIC, 16'h0000);
    fork
      macModel.send_mii(32'h22222222, 8);
      begin
        lcyc(1);
        line(1'b1, 4'ha);
        lcyc(1);
        chk(col, 1'b0);
        lcyc(2);
        chk(col, 1'b1);
        chk(crs, 1'b1);
      end
    join
    line(1'b0, 4'h0);
    lcyc(4);
  endtask : t_col10

  task automatic t_hbeat();
    int d;
    int w;
    wr(`PMMB_ADDR_PHYCTRL, 16'h0800);
    macModel.send_mii(32'h4321, 4);
    d = 0;
    w = 0;
    while (col !== 1'b1 && d < 30)
    begin
      lcyc(1);
      d++;
    end
    while (col === 1'b1 && w < 30)
    begin
      lcyc(1);
      w++;
    end
    chk(16'(d >= 6 && d <= 10), 16'h1);
    chk(16'(w >= 7 && w <= 9), 16'h1);
    wr(`PMMB_ADDR_PHYCTRL, 16'h0000);
  endtask : t_hbeat

  // Continuous stream must obey the selected recurrence (either bit order of taps)
  task automatic t_prbs(input logic p15);
    logic [479:0] b;
    int gaps;
    int ea;
    int eb;
    int ta;
    int tc;
    int tn;
    gaps = 0;
    ea = 0;
    eb = 0;
    ta = p15 ? 1 : 5;
    tc = p15 ? 14 : 4;
    tn = p15 ? 15 : 9;
    wr(`PMMB_ADDR_BASIC, 16'h2000);
    wr(`PMMB_ADDR_CDBIST, 16'h0020);
    wr(`PMMB_ADDR_PHYCTRL, {5'h0, p15, 10'h100});
    lcyc(20);
    for (int i = 0; i < 120; i++)
    begin
      @(posedge linkClk);
      gaps += (lineTx.en !== 1'b1);
      b[4*i +: 4] = lineTx.d;
    end
    for (int n = tn; n < 480; n++)
    begin
      ea += (b[n] !== (b[n-ta] ^ b[n-tn]));
      eb += (b[n] !== (b[n-tc] ^ b[n-tn]));
    end
    chk(16'(gaps), 16'h0);
    chk(16'(ea == 0 || eb == 0), 16'h1);
    chk(16'(b != '0), 16'h1);
    wr(`PMMB_ADDR_PHYCTRL, 16'h0000);
    wr(`PMMB_ADDR_CDBIST, 16'h0000);
  endtask : t_prbs

  task automatic t_bist();
    wr(`PMMB_ADDR_BASIC, 16'h6000);
    wr(`PMMB_ADDR_PHYCTRL, 16'h0100);
    lcyc(200);
    rd(`PMMB_ADDR_PHYCTRL, rv);
    chk(rv[9], 1'b1);
    rd(`PMMB_ADDR_CDBIST, rv);
    chk(rv[15:8], 8'h00);
    // All-ones line data never fits either sequence
    wr(`PMMB_ADDR_BASIC, 16'h2000);
    line(1'b1, 4'hf);
    lcyc(100);
    line(1'b0, 4'h0);
    rd(`PMMB_ADDR_CDBIST, rv);
    chk(16'(rv[15:8] != 8'h00), 16'h1);
    wr(`PMMB_ADDR_BASIC, 16'h6000);
    lcyc(100);
    rd(`PMMB_ADDR_PHYCTRL, rv);
    chk(rv[9], 1'b0);
    wr(`PMMB_ADDR_PHYCTRL, 16'h0100);
    rd(`PMMB_ADDR_CDBIST, rv);
    chk(rv[15:8], 8'h00);
    lcyc(200);
    rd(`PMMB_ADDR_PHYCTRL, rv);
    chk(rv[9], 1'b1);
    wr(`PMMB_ADDR_PHYCTRL, 16'h0000);
    wr(`PMMB_ADDR_BASIC, 16'h2000);
  endtask : t_bist

  task automatic grab(output logic [3:0] got);
    got = 4'hx;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge linkClk);
      if (lineTx.en === 1'b1)
      begin
        got = lineTx.d;
        break;
      end
    end
  endtask : grab

  // One RMII nibble at 100M, then at 10M with dibits held ten clocks
  task automatic t_rmii();
    logic [3:0] got;
    wr(`PMMB_ADDR_MAPBYP, 16'h0021);
    for (int s = 0; s < 2; s++)
    begin
      wr(`PMMB_ADDR_BASIC, s ? 16'h0000 : 16'h2000);
      fork
        macModel.send_rmii(s ? 4'h6 : 4'h9, s ? 10 : 1);
        grab(got);
      join
      chk(got, s ? 4'h6 : 4'h9);
    end
    wr(`PMMB_ADDR_MAPBYP, 16'h0001);
  endtask : t_rmii

  // RMII receive at 100M: clean frame, frame with line error, then strobed fast enough to overrun
  task automatic t_rmii_rx();
    logic [15:0] sq;
    logic        erSeen;
    int          n;
    wr(`PMMB_ADDR_MAPBYP, 16'h0021);
    wr(`PMMB_ADDR_BASIC, 16'h2000);
    for (int f = 0; f < 3; f++)
    begin
      sq     = 16'h0000;
      erSeen = 1'b0;
      n      = 0;
      fork
        begin
          for (int i = 0; i < (f == 2 ? 8 : 4); i++)
          begin
            @(negedge linkClk);
            lineRx   <= '{dv: 1'b1, er: (f == 1), d: 4'(16'h9c35 >> 4*(i%4))};
            lineStat <= 4'hf;
            @(negedge linkClk);
            lineStat <= (f == 2) ? 4'hf : 4'he;
          end
          @(negedge linkClk);
          lineRx   <= '0;
          lineStat <= '0;
        end
        repeat (40)
        begin
          @(posedge linkClk);
          if (rmiiRxDv === 1'b1)
          begin
            sq     = {rmiiRxD, sq[15:2]};
            erSeen = erSeen | (rmiiRxEr === 1'b1);
            n++;
          end
        end
      join
      if (f < 2)
      begin
        chk(16'(n), 16'h8);
        chk(sq, 16'h9c35);
      end
      chk(16'(erSeen), 16'(f != 0));
    end
    rd(`PMMB_ADDR_MAPBYP, rv);
    chk(rv[`PMMB_MB_OVER], 1'b1);
    wr(`PMMB_ADDR_MAPBYP, 16'h0001);
  endtask : t_rmii_rx

  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tallyAndFinish

  // Reset covers 12 core cycles and at least four link edges
  initial
  begin
    failCount = 0;
    cmpCount  = 0;
    srst      = 1'b1;
    regAddr   = 5'h00;
    regWrEn   = 1'b0;
    regWrData = 16'h0000;
    lineRx    = '0;
    lineStat  = '0;
    repeat (12) @(negedge core_clk);
    repeat (4) @(posedge linkClk);
    @(negedge core_clk);
    srst = 1'b0;
    lcyc(4);
    t_regs();
    t_loop();
    t_tx();
    t_col100(1'b0);
    t_col100(1'b1);
    t_col10();
    t_hbeat();
    t_prbs(1'b0);
    t_prbs(1'b1);
    t_bist();
    t_rmii();
    t_rmii_rx();
    tallyAndFinish();
  end

  // Whole run is well under 300 us
  initial
  begin
    #600000;
    failCount++;
    tallyAndFinish();
  end
endmodule : tb_top
